// *** rtl/pofs_defs.svh ***
// Offsets, field values and limits of the pixel offset register bank.
`ifndef POFS_DEFS_SVH
`define POFS_DEFS_SVH
`define POFS_BASE      16'h0F00
`define POFS_OFS_STAT  16'h0000
`define POFS_OFS_VAL   16'h0001
`define POFS_OFS_MIN   16'h0005
`define POFS_OFS_MAX   16'h0009
`define POFS_OFS_RAW   16'h000D
`define POFS_STAT_NA   8'h00
`define POFS_STAT_OK   8'h01
`define POFS_VAL_RST   32'h00000000
`define POFS_RAW_RST   16'h0000
`define POFS_MIN8_F    32'hC27C0000
`define POFS_MAX8_F    32'h427C0000
`define POFS_MIN10_F   32'hC37F0000
`define POFS_MAX10_F   32'h437F0000
`define POFS_MIN12_F   32'hC47FC000
`define POFS_MAX12_F   32'h447FC000
`define POFS_LIM8_H    20'sd6300
`define POFS_LIM10_H   20'sd25500
`define POFS_LIM12_H   20'sd102300
`define POFS_SH8       3'd4
`define POFS_SH10      3'd2
`define POFS_SH12      3'd0
`define POFS_TOP8      14'sd255
`define POFS_TOP10     14'sd1023
`define POFS_TOP12     14'sd4095
`define POFS_HUND      31'd100
`define POFS_RECIP     32'sd1311
`define POFS_RND       32'sd65536
`define POFS_RSH       17
`define POFS_FIFO_D    8
`endif

// *** rtl/pofs_pkg.sv ***
// Types shared by the pixel offset register bank.
package pofs_pkg;
    typedef enum logic [2:0]
    {
        POFS_M8  = 3'b001,
        POFS_M10 = 3'b010,
        POFS_M12 = 3'b100
    } pofs_mode_e;
    typedef struct packed
    {
        logic        line_end;
        logic [11:0] value;
    } pofs_pix_s;
endpackage

// *** rtl/pofs_regs.sv ***
// Pixel offset register bank with the offset pixel path and its FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "pofs_defs.svh"

module pofs_fifo #(
    parameter int W = 13,
    parameter int D = 8
)
(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_ff [D];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_ff != (AW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rp_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem_ff[wp_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop)
            begin
                rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module pofs_regs
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [15:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    input  wire logic [1:0]           out_mode_pin,
    input  wire logic                 offset_avail_pin,
    input  wire logic                 pix_in_valid,
    output logic                      pix_in_ready,
    input  wire pofs_pkg::pofs_pix_s  pix_in,
    output logic                      pix_out_valid,
    input  wire logic                 pix_out_ready,
    output pofs_pkg::pofs_pix_s       pix_out
);
    // Mode pins: 00 is 8 bit, 01 is 10 bit, others 12 bit.
    function automatic pofs_pkg::pofs_mode_e mode_dec(
        input logic [1:0] m
    );
        if (m == 2'b00)
        begin
            return pofs_pkg::POFS_M8;
        end
        if (m == 2'b01)
        begin
            return pofs_pkg::POFS_M10;
        end
        return pofs_pkg::POFS_M12;
    endfunction

    // Converts a float in offset units into signed hundredths, saturating.
    function automatic logic signed [19:0] f2h(input logic [31:0] f);
        logic [30:0] prod;
        logic [31:0] q;
        logic [7:0]  sh;
        logic [19:0] mag;
        prod = 31'({1'b1, f[22:0]}) * `POFS_HUND;
        sh   = 8'd150 - f[30:23];
        q    = 32'h0;
        if (f[30:23] > 8'd150)
        begin
            q = 32'hFFFFFFFF;
        end
        else if (f[30:23] != 8'h00 && sh <= 8'd31)
        begin
            q = ({1'b0, prod} + ((sh == 8'h00) ? 32'h0 :
                 (32'h1 << (sh - 8'd1)))) >> sh;
        end
        mag = (q > 32'h7FFFF) ? 20'h7FFFF : q[19:0];
        return f[31] ? -$signed(mag) : $signed(mag);
    endfunction

    // Converts a raw integer into signed hundredths of a unit.
    function automatic logic signed [19:0] r2h(
        input logic [15:0]         r,
        input pofs_pkg::pofs_mode_e m
    );
        logic signed [31:0] p;
        logic [2:0]         s;
        s = (m == pofs_pkg::POFS_M8)  ? `POFS_SH8 :
            (m == pofs_pkg::POFS_M10) ? `POFS_SH10 : `POFS_SH12;
        p = ($signed({{16{r[15]}}, r}) * 32'sd100) >>> s;
        if (p > 32'sd524287)
        begin
            return 20'sd524287;
        end
        if (p < -32'sd524287)
        begin
            return -20'sd524287;
        end
        return p[19:0];
    endfunction

    logic [1:0]           mode_s1_ff;
    logic [1:0]           mode_s2_ff;
    logic                 avail_s1_ff;
    logic                 avail_s2_ff;
    logic [31:0]          val_ff;
    logic [15:0]          raw_ff;
    logic                 src_raw_ff;
    logic signed [19:0]   hund_ff;
    logic signed [13:0]   ofs_dn_ff;
    logic [7:0]           stat_ff;
    logic [31:0]          reg_rdata_ff;
    pofs_pkg::pofs_mode_e mode;
    logic signed [19:0]   lim;
    logic [31:0]          min_f;
    logic [31:0]          max_f;
    logic signed [13:0]   top;
    logic signed [31:0]   dn_full;
    logic signed [14:0]   sum;
    pofs_pkg::pofs_pix_s  adj;
    logic                 wr_val;
    logic                 wr_raw;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mode_s1_ff  <= 2'h0;
            mode_s2_ff  <= 2'h0;
            avail_s1_ff <= 1'b0;
            avail_s2_ff <= 1'b0;
        end
        else
        begin
            mode_s1_ff  <= out_mode_pin;
            mode_s2_ff  <= mode_s1_ff;
            avail_s1_ff <= offset_avail_pin;
            avail_s2_ff <= avail_s1_ff;
        end
    end

    assign mode  = mode_dec(mode_s2_ff);
    // Range limits follow the output mode.
    always_comb
    begin
        unique case (mode)
            pofs_pkg::POFS_M8:
            begin
                lim   = `POFS_LIM8_H;
                min_f = `POFS_MIN8_F;
                max_f = `POFS_MAX8_F;
                top   = `POFS_TOP8;
            end
            pofs_pkg::POFS_M10:
            begin
                lim   = `POFS_LIM10_H;
                min_f = `POFS_MIN10_F;
                max_f = `POFS_MAX10_F;
                top   = `POFS_TOP10;
            end
            default:
            begin
                lim   = `POFS_LIM12_H;
                min_f = `POFS_MIN12_F;
                max_f = `POFS_MAX12_F;
                top   = `POFS_TOP12;
            end
        endcase
    end

    assign wr_val = reg_wr && reg_addr == `POFS_BASE + `POFS_OFS_VAL;
    assign wr_raw = reg_wr && reg_addr == `POFS_BASE + `POFS_OFS_RAW;

    // Only the float and raw fields take writes.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            val_ff     <= `POFS_VAL_RST;
            raw_ff     <= `POFS_RAW_RST;
            src_raw_ff <= 1'b0;
        end
        else if (wr_val)
        begin
            val_ff     <= reg_wdata;
            src_raw_ff <= 1'b0;
        end
        else if (wr_raw)
        begin
            raw_ff     <= reg_wdata[15:0];
            src_raw_ff <= 1'b1;
        end
    end

    // The last written field sets the offset in hundredths of a unit.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            hund_ff <= 20'sd0;
        end
        else
        begin
            hund_ff <= src_raw_ff ? r2h(raw_ff, mode)
                                  : f2h(val_ff);
        end
    end

    assign dn_full = ($signed({{12{hund_ff[19]}}, hund_ff})
                     * `POFS_RECIP + `POFS_RND) >>> `POFS_RSH;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ofs_dn_ff <= 14'sd0;
            stat_ff   <= `POFS_STAT_NA;
        end
        else
        begin
            ofs_dn_ff <= dn_full[13:0];
            stat_ff   <= (avail_s2_ff && hund_ff >= -lim && hund_ff <= lim)
                         ? `POFS_STAT_OK : `POFS_STAT_NA;
        end
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge sys_clk)
    begin
        if (rst || !reg_rd)
        begin
            reg_rdata_ff <= 32'h0;
        end
        else
        begin
            unique case (reg_addr)
                `POFS_BASE + `POFS_OFS_STAT:
                    reg_rdata_ff <= {24'h0, stat_ff};
                `POFS_BASE + `POFS_OFS_VAL:
                    reg_rdata_ff <= val_ff;
                `POFS_BASE + `POFS_OFS_MIN:
                    reg_rdata_ff <= min_f;
                `POFS_BASE + `POFS_OFS_MAX:
                    reg_rdata_ff <= max_f;
                `POFS_BASE + `POFS_OFS_RAW:
                    reg_rdata_ff <= {16'h0, raw_ff};
                default:
                    reg_rdata_ff <= 32'h0;
            endcase
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // Adds the offset and clamps to the mode's code range.
    always_comb
    begin
        sum = $signed({3'b000, pix_in.value}) + 15'(ofs_dn_ff);
        adj.line_end = pix_in.line_end;
        if (sum < 15'sd0)
        begin
            adj.value = 12'h000;
        end
        else if (sum > 15'(top))
        begin
            adj.value = top[11:0];
        end
        else
        begin
            adj.value = sum[11:0];
        end
    end

    pofs_fifo #(
        .W ($bits(pofs_pkg::pofs_pix_s)),
        .D (`POFS_FIFO_D)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (pix_in_valid),
        .in_ready  (pix_in_ready),
        .in_data   (adj),
        .out_valid (pix_out_valid),
        .out_ready (pix_out_ready),
        .out_data  (pix_out)
    );
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_status_read: assert property (
        reg_rd && reg_addr == `POFS_BASE + `POFS_OFS_STAT |=>
        reg_rdata == {24'h0, $past(stat_ff)})
        else $error("Status byte read back wrong.");
    a_status_code: assert property (
        !avail_s2_ff |=> stat_ff == `POFS_STAT_NA)
        else $error("Status not zero while unavailable.");
    a_float_write: assert property (
        wr_val |=> val_ff == $past(reg_wdata) && !src_raw_ff)
        else $error("Float offset write not taken.");
    a_raw_write: assert property (
        wr_raw |=> raw_ff == $past(reg_wdata[15:0]) && src_raw_ff)
        else $error("Raw offset write not taken.");
    a_float_conv: assert property (
        !src_raw_ff && val_ff == 32'h401F5C29 |=> hund_ff == 20'sd249)
        else $error("Float not resolved to hundredths.");
    a_raw_scale: assert property (
        src_raw_ff && mode == pofs_pkg::POFS_M8 && raw_ff == 16'h0010
        |=> hund_ff == 20'sd100)
        else $error("Sixteen raw steps not one unit.");
    a_min_read: assert property (
        reg_rd && reg_addr == `POFS_BASE + `POFS_OFS_MIN |=>
        reg_rdata == $past(min_f))
        else $error("Lower limit read back wrong.");
    a_max_read: assert property (
        reg_rd && reg_addr == `POFS_BASE + `POFS_OFS_MAX |=>
        reg_rdata == $past(max_f))
        else $error("Upper limit read back wrong.");
    a_range_ok: assert property (
        stat_ff == `POFS_STAT_OK |->
        $past(hund_ff) <= $past(lim) && $past(hund_ff) >= -$past(lim))
        else $error("Status good with offset out of range.");
    a_ro_ignored: assert property (
        reg_wr && !wr_val && !wr_raw |=>
        $stable(val_ff) && $stable(raw_ff) && $stable(src_raw_ff))
        else $error("Write to read-only field changed state.");
    a_float_fmt: assert property (
        !src_raw_ff && val_ff == 32'h40A00000 |=>
        hund_ff == 20'sd500)
        else $error("Float five not decoded as five units.");
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking testbench for the pixel offset register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pofs_defs.svh"

module tb;
    logic                sys_clk;
    logic                rst;
    logic [15:0]         reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [31:0]         reg_rdata;
    logic [1:0]          out_mode_pin;
    logic                offset_avail_pin;
    logic                pix_in_valid;
    logic                pix_in_ready;
    pofs_pkg::pofs_pix_s pix_in;
    logic                pix_out_valid;
    logic                pix_out_ready;
    pofs_pkg::pofs_pix_s pix_out;
    int                  err_total;
    int                  n_compared;
    int                  cycles;
    int                  seed;
    int                  dn;
    int                  top;
    int                  li;
    logic [12:0]         exp_q[$];
    logic [31:0]         flt[4];
    int                  fdn[4];
    logic [31:0]         rawv[3];
    int                  rawdn[3];
    logic [31:0]         lim[3][2];

    pofs_regs DUT
    (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .out_mode_pin     (out_mode_pin),
        .offset_avail_pin (offset_avail_pin),
        .pix_in_valid     (pix_in_valid),
        .pix_in_ready     (pix_in_ready),
        .pix_in           (pix_in),
        .pix_out_valid    (pix_out_valid),
        .pix_out_ready    (pix_out_ready),
        .pix_out          (pix_out)
    );

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize;
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input string nm, input logic [15:0] a,
                      input logic [31:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk(nm, reg_rdata, e);
    endtask

    task automatic push(input logic [11:0] v);
        int s;
        s = int'(v) + dn;
        if (s < 0)
            s = 0;
        if (s > top)
            s = top;
        pix_in       <= {v[0], v};
        pix_in_valid <= 1'b1;
        if (pix_in_ready === 1'b1)
            exp_q.push_back({v[0], 12'(s)});
        @(posedge sys_clk);
        pix_in_valid <= 1'b0;
        #1;
    endtask

    task automatic drain;
        int n;
        n = 0;
        pix_out_ready <= 1'b1;
        while (exp_q.size() > 0 && n < 40)
        begin
            if (pix_out_valid === 1'b1)
                chk("pixel", {19'h0, pix_out},
                    {19'h0, exp_q.pop_front()});
            idle(1);
            n++;
        end
        pix_out_ready <= 1'b0;
        chk("pending pixels", 32'(exp_q.size()), 32'h00000000);
    endtask

    task automatic pixels;
        push(12'(top));
        push(12'h000);
        push(12'($random(seed)) & 12'(top));
        drain();
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            summarize();
        end
    end

    initial
    begin
        seed = 80904;
        err_total = 0;
        n_compared = 0;
        cycles = 0;
        dn = 0;
        top = 255;
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        out_mode_pin = 2'h0;
        offset_avail_pin = 1'b0;
        pix_in_valid = 1'b0;
        pix_in = '0;
        pix_out_ready = 1'b0;
        flt = '{32'h40A00000, 32'h401F5C29, 32'h4020A3D7, 32'hC0A00000};
        fdn = '{5, 2, 3, -5};
        rawv = '{32'h00000010, 32'h0000FFF0, 32'h00000007};
        rawdn = '{1, -4, 7};
        lim = '{'{`POFS_MIN8_F, `POFS_MAX8_F},
                '{`POFS_MIN10_F, `POFS_MAX10_F},
                '{`POFS_MIN12_F, `POFS_MAX12_F}};
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        idle(6);
        rd("status", 16'h0F00, 32'h00000000);
        rd("unmapped", 16'h0F20, 32'h00000000);
        offset_avail_pin <= 1'b1;
        idle(6);
        rd("status", 16'h0F00, 32'h00000001);
        for (int m = 0; m < 4; m++)
        begin
            out_mode_pin <= m[1:0];
            li = (m > 2) ? 2 : m;
            idle(6);
            wr(16'h0F00, 32'hFFFFFFFF);
            wr(16'h0F05, 32'h12345678);
            wr(16'h0F09, 32'h9ABCDEF0);
            idle(4);
            rd("min", 16'h0F05, lim[li][0]);
            rd("max", 16'h0F09, lim[li][1]);
            rd("status", 16'h0F00, 32'h00000001);
        end
        out_mode_pin <= 2'h0;
        top = 255;
        idle(6);
        for (int i = 0; i < 4; i++)
        begin
            wr(16'h0F01, flt[i]);
            idle(4);
            dn = fdn[i];
            rd("float", 16'h0F01, flt[i]);
            pixels();
        end
        wr(16'h0F01, 32'h42C80000);
        idle(4);
        rd("status", 16'h0F00, 32'h00000000);
        for (int m = 0; m < 3; m++)
        begin
            out_mode_pin <= m[1:0];
            top = (m == 0) ? 255 : (m == 1) ? 1023 : 4095;
            idle(6);
            wr(16'h0F0D, rawv[m]);
            idle(4);
            dn = rawdn[m];
            pixels();
            rd("status", 16'h0F00, 32'h00000001);
            rd("raw", 16'h0F0D, rawv[m]);
        end
        repeat (9) push(12'($random(seed)) & 12'(top));
        chk("fifo fill", 32'(exp_q.size()), 32'h00000008);
        chk("in ready", {31'h0, pix_in_ready}, 32'h00000000);
        drain();
        summarize();
    end
endmodule
`default_nettype wire
